// File: msj_defs.svh
// Constants for the multispeed and jog selector: register offsets, field codes, reset values.
// Assumes frequencies in 0.1 Hz steps and a 6-bit word-indexed register port.
`ifndef MSJ_DEFS_SVH
`define MSJ_DEFS_SVH

`define MSJ_FREQ_W        16
`define MSJ_ADDR_W        6
`define MSJ_NUM_PRESETS   16
`define MSJ_NUM_TERMS     5
`define MSJ_CODE_W        5

`define MSJ_OFF_PRESET0   6'h00
`define MSJ_OFF_MAIN_FREQ 6'h10
`define MSJ_OFF_MAX_FREQ  6'h11
`define MSJ_OFF_START_FRQ 6'h12
`define MSJ_OFF_JOG_FREQ  6'h13
`define MSJ_OFF_JOG_STOP  6'h14
`define MSJ_OFF_FREQ_SRC  6'h15
`define MSJ_OFF_RUN_SRC   6'h16
`define MSJ_OFF_TFUNC0    6'h18
`define MSJ_OFF_STATUS    6'h20
`define MSJ_OFF_MONITOR   6'h21

`define MSJ_FN_FWD        5'h00
`define MSJ_FN_SPD_BIT0   5'h02
`define MSJ_FN_JOG        5'h06
`define MSJ_FN_NONE       5'h1f

`define MSJ_FSRC_TERM     2'h2
`define MSJ_RSRC_TERM     2'h1

`define MSJ_JOG_CAP       16'h0064
`define MSJ_RST_MAX_FREQ  16'h01f4
`define MSJ_RST_MAIN_FREQ 16'h0000
`define MSJ_RST_START_FRQ 16'h0005
`define MSJ_RST_JOG_FREQ  16'h0032
`define MSJ_RST_PRESET    16'h0000
`define MSJ_RST_TFUNC1    5'h00
`define MSJ_RST_TFUNC2    5'h02
`define MSJ_RST_TFUNC3    5'h03
`define MSJ_RST_TFUNC4    5'h04
`define MSJ_RST_TFUNC5    5'h06

`endif

// File: msj_pkg.sv
// Types shared by the multispeed and jog selector.
// Assumes msj_defs.svh supplies the widths.
`include "msj_defs.svh"

package msj_pkg;

  typedef enum logic [1:0] {
    MSJ_STOP_COAST = 2'b00,
    MSJ_STOP_DECEL = 2'b01,
    MSJ_STOP_DCBRK = 2'b10
  } msj_stop_e;

  typedef struct packed {
    logic                    store;
    logic                    term_mode;
    logic [3:0]              idx;
    logic [`MSJ_FREQ_W-1:0]  value;
  } msj_kp_s;

  typedef struct packed {
    logic                    run;
    logic                    fwd;
    logic                    jog;
    logic                    jog_end;
    msj_stop_e               stop_method;
    logic [3:0]              speed_idx;
    logic [`MSJ_FREQ_W-1:0]  freq;
  } msj_drive_s;

endpackage

// File: msj_select.sv
// Multispeed and jog target-frequency selector with its parameter registers.
// Assumes terminals and keypad signals are synchronous to clk_sys; bus master never waits.
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "msj_defs.svh"

module msj_select
  import msj_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire logic [`MSJ_ADDR_W-1:0]      bus_addr,
  input  wire logic [`MSJ_FREQ_W-1:0]      bus_wdata,
  input  wire logic                        bus_wr,
  input  wire logic                        bus_rd,
  output logic      [`MSJ_FREQ_W-1:0]      bus_rdata,
  input  wire logic [`MSJ_NUM_TERMS-1:0]   term_in,
  input  wire logic                        kp_run,
  input  wire msj_kp_s                     kp,
  output msj_drive_s                       drive
);

  logic [`MSJ_FREQ_W-1:0] preset_ff [`MSJ_NUM_PRESETS];
  logic [`MSJ_CODE_W-1:0] tfunc_ff  [`MSJ_NUM_TERMS];
  logic [`MSJ_FREQ_W-1:0] main_freq_ff;
  logic [`MSJ_FREQ_W-1:0] max_freq_ff;
  logic [`MSJ_FREQ_W-1:0] start_freq_ff;
  logic [`MSJ_FREQ_W-1:0] jog_freq_ff;
  msj_stop_e              jog_stop_ff;
  logic [1:0]             freq_src_ff;
  logic [1:0]             run_src_ff;
  logic [`MSJ_NUM_TERMS-1:0] term_ff;
  logic [3:0]             speed_idx_ff;
  logic                   jog_ff;
  msj_drive_s             drive_ff;
  logic [`MSJ_FREQ_W-1:0] rdata_ff;
  logic [`MSJ_FREQ_W-1:0] nxt_rdata;

  // Per-bit terminal decode
  logic [3:0]             speed_code;
  logic [`MSJ_NUM_TERMS-1:0] fwd_hit;
  logic [`MSJ_NUM_TERMS-1:0] jog_hit;
  logic [`MSJ_NUM_TERMS-1:0] bit_hit [4];

  genvar t;
  genvar b;
  generate
    for (t = 0; t < `MSJ_NUM_TERMS; t++) begin : g_term
      assign fwd_hit[t] = term_ff[t] && (tfunc_ff[t] == `MSJ_FN_FWD);
      assign jog_hit[t] = term_ff[t] && (tfunc_ff[t] == `MSJ_FN_JOG);
      for (b = 0; b < 4; b++) begin : g_bit
        // Any terminal, any order; a bit with no terminal stays zero
        assign bit_hit[b][t] = term_ff[t] &&
          (tfunc_ff[t] == `MSJ_FN_SPD_BIT0 + 5'(b));
      end
    end
    for (b = 0; b < 4; b++) begin : g_code
      assign speed_code[b] = |bit_hit[b];
    end
  endgenerate

  // Command decode
  wire term_run_src = (run_src_ff == `MSJ_RSRC_TERM);
  wire fwd_cmd      = |fwd_hit;
  wire jog_in       = |jog_hit;
  wire run_cmd      = term_run_src ? fwd_cmd : kp_run;
  wire freq_term    = (freq_src_ff == `MSJ_FSRC_TERM);

  // Jog frequency legality and cap
  wire jog_legal = (jog_freq_ff != '0) &&
                   (jog_freq_ff >= start_freq_ff);
  wire [`MSJ_FREQ_W-1:0] jog_target =
    (jog_freq_ff > `MSJ_JOG_CAP) ? `MSJ_JOG_CAP : jog_freq_ff;
  // Jog needs terminal run routing; otherwise the run key gives a plain run
  wire jog_now = jog_in && run_cmd && term_run_src && jog_legal;
  wire run_now   = run_cmd || jog_now;
  wire kp_fwd    = !term_run_src && kp_run;
  wire jog_ended = jog_ff && !jog_now;

  // Steady target selection
  wire [`MSJ_FREQ_W-1:0] sel_freq =
    freq_term ? preset_ff[speed_idx_ff] : main_freq_ff;
  wire [`MSJ_FREQ_W-1:0] lim_freq =
    (sel_freq > max_freq_ff) ? max_freq_ff : sel_freq;
  wire [`MSJ_FREQ_W-1:0] jog_lim =
    (jog_target > max_freq_ff) ? max_freq_ff : jog_target;

  // Output frequency: jog steps straight to its value, no ramp here
  wire [`MSJ_FREQ_W-1:0] nxt_freq =
    jog_now ? jog_lim : (run_cmd ? lim_freq : '0);

  // Store paths
  wire term_store = kp.store && kp.term_mode && !run_cmd && freq_term;
  wire kp_store   = kp.store && !kp.term_mode;
  wire [3:0] store_idx = kp.term_mode ? speed_idx_ff : kp.idx;
  wire store_any  = term_store || kp_store;

  // Bus write decode
  wire wr_preset = bus_wr && (bus_addr[5:4] == 2'b00);
  wire wr_main   = bus_wr && (bus_addr == `MSJ_OFF_MAIN_FREQ);
  wire wr_max    = bus_wr && (bus_addr == `MSJ_OFF_MAX_FREQ);
  wire wr_start  = bus_wr && (bus_addr == `MSJ_OFF_START_FRQ);
  wire wr_jog    = bus_wr && (bus_addr == `MSJ_OFF_JOG_FREQ);
  wire wr_jstop  = bus_wr && (bus_addr == `MSJ_OFF_JOG_STOP);
  wire wr_fsrc   = bus_wr && (bus_addr == `MSJ_OFF_FREQ_SRC);
  wire wr_rsrc   = bus_wr && (bus_addr == `MSJ_OFF_RUN_SRC);
  wire [2:0] tf_idx = 3'(bus_addr - `MSJ_OFF_TFUNC0);
  // Bounded above as well, or writes to the status words would alias onto the map
  wire tf_range  = (bus_addr >= `MSJ_OFF_TFUNC0) && (bus_addr < `MSJ_OFF_STATUS) &&
                   (tf_idx < 3'(`MSJ_NUM_TERMS));
  wire wr_tfunc  = bus_wr && tf_range;
  // Code 11 names no stop method, so such a write is dropped
  wire jstop_ok  = (bus_wdata[1:0] != 2'b11);

  // Presets: bus write and keypad store share one write port, bus first
  genvar p;
  generate
    for (p = 0; p < `MSJ_NUM_PRESETS; p++) begin : g_preset
      wire hit_bus = wr_preset && (bus_addr[3:0] == 4'(p));
      wire hit_kp  = store_any && (store_idx == 4'(p));
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          preset_ff[p] <= `MSJ_RST_PRESET;
        end else if (hit_bus) begin
          preset_ff[p] <= bus_wdata;
        end else if (hit_kp) begin
          preset_ff[p] <= kp.value;
        end
      end
    end
  endgenerate

  localparam logic [`MSJ_CODE_W-1:0] TFUNC_RST [`MSJ_NUM_TERMS] = '{
    `MSJ_RST_TFUNC1, `MSJ_RST_TFUNC2, `MSJ_RST_TFUNC3,
    `MSJ_RST_TFUNC4, `MSJ_RST_TFUNC5};

  generate
    for (t = 0; t < `MSJ_NUM_TERMS; t++) begin : g_tfunc
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          tfunc_ff[t] <= TFUNC_RST[t];
        end else if (wr_tfunc && (tf_idx == 3'(t))) begin
          tfunc_ff[t] <= bus_wdata[`MSJ_CODE_W-1:0];
        end
      end
    end
  endgenerate

  // Configuration registers, one short process each
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      main_freq_ff <= `MSJ_RST_MAIN_FREQ;
    end else if (wr_main) begin
      main_freq_ff <= bus_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      max_freq_ff <= `MSJ_RST_MAX_FREQ;
    end else if (wr_max) begin
      max_freq_ff <= bus_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      start_freq_ff <= `MSJ_RST_START_FRQ;
    end else if (wr_start) begin
      start_freq_ff <= bus_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      jog_freq_ff <= `MSJ_RST_JOG_FREQ;
    end else if (wr_jog) begin
      jog_freq_ff <= bus_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      jog_stop_ff <= MSJ_STOP_DECEL;
    end else if (wr_jstop && jstop_ok) begin
      jog_stop_ff <= msj_stop_e'(bus_wdata[1:0]);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      freq_src_ff <= `MSJ_FSRC_TERM;
    end else if (wr_fsrc) begin
      freq_src_ff <= bus_wdata[1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run_src_ff <= `MSJ_RSRC_TERM;
    end else if (wr_rsrc) begin
      run_src_ff <= bus_wdata[1:0];
    end
  end

  // Terminal sampling; the switches are taken as already synchronous
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      term_ff <= '0;
    end else begin
      term_ff <= term_in;
    end
  end

  // Registered index, so a code change reaches the target in one clean step
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      speed_idx_ff <= '0;
      jog_ff       <= 1'b0;
    end else begin
      speed_idx_ff <= speed_code;
      jog_ff       <= jog_now;
    end
  end

  // Drive outputs from flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      drive_ff <= '0;
    end else begin
      drive_ff.run         <= run_now;
      drive_ff.fwd         <= fwd_cmd || kp_fwd;
      drive_ff.jog         <= jog_now;
      drive_ff.jog_end     <= jog_ended;
      drive_ff.stop_method <= jog_stop_ff;
      drive_ff.speed_idx   <= speed_idx_ff;
      drive_ff.freq        <= nxt_freq;
    end
  end

  assign drive = drive_ff;

  // Read decode; unmapped addresses return zero
  always_comb begin
    nxt_rdata = '0;
    if (bus_addr[5:4] == 2'b00) begin
      nxt_rdata = preset_ff[bus_addr[3:0]];
    end else if (bus_addr == `MSJ_OFF_MAIN_FREQ) begin
      nxt_rdata = main_freq_ff;
    end else if (bus_addr == `MSJ_OFF_MAX_FREQ) begin
      nxt_rdata = max_freq_ff;
    end else if (bus_addr == `MSJ_OFF_START_FRQ) begin
      nxt_rdata = start_freq_ff;
    end else if (bus_addr == `MSJ_OFF_JOG_FREQ) begin
      nxt_rdata = jog_freq_ff;
    end else if (bus_addr == `MSJ_OFF_JOG_STOP) begin
      nxt_rdata = {14'h0000, jog_stop_ff};
    end else if (bus_addr == `MSJ_OFF_FREQ_SRC) begin
      nxt_rdata = {14'h0000, freq_src_ff};
    end else if (bus_addr == `MSJ_OFF_RUN_SRC) begin
      nxt_rdata = {14'h0000, run_src_ff};
    end else if (tf_range) begin
      nxt_rdata = {11'h000, tfunc_ff[tf_idx]};
    end else if (bus_addr == `MSJ_OFF_STATUS) begin
      nxt_rdata = {5'h00, drive_ff.stop_method, jog_legal, drive_ff.jog,
                   drive_ff.fwd, drive_ff.run, drive_ff.speed_idx, 1'b0};
    end else if (bus_addr == `MSJ_OFF_MONITOR) begin
      nxt_rdata = drive_ff.freq;
    end
  end

  // Read data holds only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= bus_rd ? nxt_rdata : '0;
    end
  end

  assign bus_rdata = rdata_ff;

endmodule

// File: msj_select_sva.sv
// Checker for the preset speed and jog selector, on top-level ports only.
// Assumes the default terminal map: t1 forward run, t5 jog when jog is used.
`timescale 1ns/1ps
`include "msj_defs.svh"
module msj_chk
  import msj_pkg::*;
(
  input wire logic                      clk_sys,
  input wire logic                      rst_n,
  input wire logic [`MSJ_ADDR_W-1:0]    bus_addr,
  input wire logic [`MSJ_FREQ_W-1:0]    bus_wdata,
  input wire logic                      bus_wr,
  input wire logic                      bus_rd,
  input wire logic [`MSJ_FREQ_W-1:0]    bus_rdata,
  input wire logic [`MSJ_NUM_TERMS-1:0] term_in,
  input wire logic                      kp_run,
  input wire msj_kp_s                   kp,
  input wire msj_drive_s                drive
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_rdata_quiet: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
    else $error("read data outside its slot");
  a_jog_cap: assert property (drive.jog |-> drive.freq <= `MSJ_JOG_CAP)
    else $error("jog frequency above cap");
  a_jog_with_run: assert property (drive.jog |-> drive.run)
    else $error("jog without run");
  a_jog_from_term: assert property ($rose(drive.jog) |->
    $past(term_in[4], 2) || $past(term_in[4], 3)) else $error("jog with input off");
  a_jog_end_once: assert property (drive.jog_end |=> !drive.jog_end)
    else $error("jog end pulse too long");
  a_stop_code_legal: assert property (drive.stop_method != 2'b11)
    else $error("illegal stop method");
  a_idle_freq_zero: assert property (!drive.run |-> drive.freq == 16'h0000)
    else $error("frequency while stopped");
  // The run key reaches the command one stage earlier than a terminal does
  a_run_cause: assert property ($rose(drive.run) |-> $past(term_in[0], 2)
    || $past(term_in[0], 3) || $past(kp_run) || $past(kp_run, 2))
    else $error("run without command");
  a_freq_steady: assert property (($stable(term_in) && $stable(kp_run) && !bus_wr
    && !kp.store) [*6] |-> $stable(drive.freq)) else $error("frequency moved");
  c_jog: cover property (drive.jog);
  c_jog_end: cover property (drive.jog_end);
  c_top_speed: cover property (drive.run && drive.speed_idx == 4'hf);
endmodule
bind msj_select msj_chk msj_chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .term_in(term_in), .kp_run(kp_run), .kp(kp), .drive(drive));

// File: msj_far.sv
// Switches on the terminals and the operator keypad.
// Assumes the bench asks for switch states and key presses once per cycle.
`timescale 1ns/1ps
`include "msj_defs.svh"
module msj_far
  import msj_pkg::*;
(
  input wire logic                      clk_sys,
  input wire logic                      rst_n,
  input wire logic [4:0]                sw,
  input wire logic                      press,
  input wire logic                      kmode,
  input wire logic [3:0]                kidx,
  input wire logic [`MSJ_FREQ_W-1:0]    kval,
  output logic     [`MSJ_NUM_TERMS-1:0] term_in,
  output msj_kp_s                       kp
);
  // Operator drops forward run for a cycle whenever jog flips
  wire flip = sw[4] != term_in[4];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      term_in <= '0;
      kp      <= '0;
    end else begin
      term_in <= flip ? {sw[4:1], 1'b0} : sw;
      kp      <= '{press, kmode, kidx, kval};
    end
  end
endmodule

// File: test_multispeed_and_jog_select.sv
// Self-checking bench for the selector with switch and keypad model.
// Assumes the register offsets and reset values of msj_defs.svh.
`timescale 1ns/1ps
`include "msj_defs.svh"
module test_multispeed_and_jog_select
  import msj_pkg::*;
;
  logic        clk_sys = 0, rst_n = 0, bus_wr = 0, bus_rd = 0, kp_run = 0;
  logic [5:0]  bus_addr = '0;
  logic [15:0] bus_wdata = '0, bus_rdata, kval = '0, v[16];
  logic [4:0]  sw = '0, term_in;
  logic        press = 0, kmode = 0, rd_d = 0;
  logic [3:0]  kidx = '0;
  msj_kp_s     kp;
  msj_drive_s  drive;
  logic [37:0] q[$];
  logic [37:0] n;
  int          failures = 0, samples_checked = 0, cyc = 0;
  always #20 clk_sys = ~clk_sys;
  msj_select msj_select_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .term_in(term_in), .kp_run(kp_run), .kp(kp), .drive(drive));
  msj_far msj_far_i (.clk_sys(clk_sys), .rst_n(rst_n), .sw(sw), .press(press),
    .kmode(kmode), .kidx(kidx), .kval(kval), .term_in(term_in), .kp(kp));
  task close_out;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp(logic [5:0] a, logic [15:0] e, logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("ERROR reg %h exp %h got %h", a, e, s);
    end
  endtask
  task wr(logic [5:0] a, logic [15:0] d);
    @(posedge clk_sys);
    {bus_wr, bus_addr, bus_wdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    bus_wr <= 0;
  endtask
  task rd(logic [5:0] a, logic [15:0] e, logic [15:0] m = 16'hffff);
    @(posedge clk_sys);
    {bus_rd, bus_addr} <= {1'b1, a};
    q.push_back({a, e, m});
    @(posedge clk_sys);
    bus_rd <= 0;
  endtask
  task go(logic [4:0] s);
    sw <= s;
    repeat (6) @(posedge clk_sys);
  endtask
  task key(logic m, logic [3:0] i, logic [15:0] d, logic p);
    @(posedge clk_sys);
    {press, kmode, kidx, kval} <= {p, m, i, d};
    @(posedge clk_sys);
    press <= 0;
    repeat (3) @(posedge clk_sys);
  endtask
  // Read results land one cycle after the strobe; oldest note first
  always @(posedge clk_sys) begin
    rd_d <= bus_rd;
    cyc++;
    if (rd_d) begin
      n = q.pop_front();
      cmp(n[37:32], n[31:16], bus_rdata & n[15:0]);
    end
    if (cyc == 20000) begin
      failures++;
      close_out;
    end
  end
  initial begin
    void'($urandom(53801));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1;
    rd(6'h11, 16'h01f4);
    rd(6'h13, 16'h0032);
    rd(6'h15, 16'h0002);
    rd(6'h3f, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      v[i] = 16'($urandom % 500);
      wr(6'(i), v[i]);
    end
    for (int i = 0; i < 8; i++) begin
      go({1'b0, 3'(i), 1'b1});
      rd(6'h21, v[i]);
      rd(6'h20, {8'h00, 3'b011, 4'(i), 1'b0}, 16'h00fe);
    end
    wr(6'h07, 16'h0300);
    go(5'h0f);
    rd(6'h21, 16'h01f4);
    wr(6'h1c, 16'h0005);
    go(5'h1f);
    rd(6'h21, v[15]);
    wr(6'h1c, 16'h001f);
    go(5'h13);
    rd(6'h21, v[1]);
    wr(6'h1c, 16'h0006);
    wr(6'h15, 16'h0000);
    wr(6'h10, 16'h0123);
    go(5'h05);
    rd(6'h21, 16'h0123);
    go(5'h04);
    key(1, 4'h0, 16'h0055, 1);
    rd(6'h02, v[2]);
    wr(6'h15, 16'h0002);
    key(0, 4'h3, 16'h0077, 0);
    rd(6'h03, v[3]);
    key(0, 4'h3, 16'h0077, 1);
    rd(6'h03, 16'h0077);
    go(5'h04);
    key(1, 4'h0, 16'h0088, 1);
    rd(6'h02, 16'h0088);
    go(5'h05);
    key(1, 4'h0, 16'h0099, 1);
    rd(6'h02, 16'h0088);
    go(5'h10);
    go(5'h11);
    rd(6'h21, 16'h0032);
    rd(6'h20, 16'h00a0, 16'h00a0);
    wr(6'h13, 16'h00c8);
    rd(6'h21, 16'h0064);
    wr(6'h13, 16'h0005);
    rd(6'h21, 16'h0005);
    for (int m = 0; m < 4; m++) begin
      wr(6'h14, 16'(m));
      rd(6'h20, 16'(m == 3 ? 2 : m) << 9, 16'h0600);
    end
    foreach (v[k]) if (k < 2) begin
      wr(6'h13, 16'(k * 4));
      rd(6'h20, 16'h0000, 16'h0080);
    end
    go(5'h01);
    wr(6'h16, 16'h0000);
    kp_run <= 1;
    go(5'h10);
    rd(6'h20, 16'h0020, 16'h00a0);
    kp_run <= 0;
    go(5'h00);
    rd(6'h21, 16'h0000);
    close_out;
  end
endmodule
